// ### spi_far_peer.sv
// Far-end serial peer: bit and character timing, sync pin level
`timescale 1ns/10ps
`default_nettype none
module spi_far_peer (
	input  wire logic mclk,
	input  wire logic rstn,
	input  wire logic xferActive,
	input  wire logic syncPulse,
	input  wire logic syncActiveHigh,
	output logic      bitTick,
	output logic      charDone,
	output logic      selectPinIn
);
	logic [4:0] phase_r;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			phase_r <= 5'h00;
		else
			phase_r <= xferActive ? phase_r + 5'h01 : 5'h00;
	end
	assign bitTick = xferActive && (phase_r[1:0] == 2'h3);
	assign charDone = xferActive && (phase_r == 5'h1F);
	// Pin rests at its inactive level between frames
	assign selectPinIn = syncPulse ~^ syncActiveHigh;
endmodule
`default_nettype wire

// ### spi_framing_control.sv
// Framing, select and clock source control for the serial interface
// Contract
// - Framed mode turns the select pin into a frame sync, in or out.
// - Sync direction 1 makes sync an input, 0 makes device drive it.
// - Sync polarity 1 means active-high pulse, 0 active-low.
// - Auto select drives select pin during master transfers, level from polarity.
// - Pulse width 1 lasts a character, 0 lasts one serial clock.
// - Count codes 0..5 give one pulse per 1..32 characters; 6,7 reserved. At width 0 the code pulses each serial clock of a group's first character.
// - Count field acts only in framed mode.
// - Clock source 1 picks reference clock one, 0 peripheral bus clock two.
// - Clock source and enhanced buffer bits writable only while disabled.
// - Output edge select ignored in framed mode; software keeps it zero.
// - Audio mode forces idle clock polarity to one.
// - Serial in and out disable bits are legacy only, stored but unused.
// - Unimplemented bits read zero and ignore writes.
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
module spi_framing_control
	import spi_framing_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic             waitrequest,
	output logic [31:0]      readdata,
	input  wire logic        audio_protocol_enable,
	input  wire logic        charDone,
	input  wire logic        bitTick,
	input  wire logic        xferActive,
	input  wire logic        selectPinIn,
	output logic             selectPinOut,
	output logic             selectPinOe,
	output logic             frameStart,
	output logic             baudClockSourceSel,
	output logic             effectiveIdlePolarity,
	output logic             effectiveEdgeSel
);
	typedef enum logic [2:0] {
		BUS_IDLE = 3'b001,
		BUS_ACK  = 3'b010,
		BUS_DONE = 3'b100
	} bus_state_t;

	bus_state_t  busState_r, busState_nxt;
	logic [31:0] control_r, control_nxt;
	logic [31:0] readdata_r, readdata_nxt;
	logic [4:0]  charCnt_r, charCnt_nxt;
	logic        pulseActive_r, pulseActive_nxt;
	logic        selOut_r, selOut_nxt;
	logic        selOe_r, selOe_nxt;
	logic        frameStart_r, frameStart_nxt;
	logic        clkSrc_r, clkSrc_nxt;
	logic        idlePol_r, idlePol_nxt;
	logic        edgeSel_r, edgeSel_nxt;
	logic        syncMeta_r, syncSync_r, syncPrev_r;
	logic [31:0] beMask;
	logic [31:0] wrMask;
	logic [4:0]  charLimit;
	logic        framed, syncIn, enabled, polarity, syncSeen;

	assign framed   = control_r[FRAMED_BIT];
	assign syncIn   = control_r[SYNCDIR_BIT];
	assign polarity = control_r[SYNCPOL_BIT];
	assign enabled  = control_r[ENABLE_BIT];
	// Incoming sync is seen at its active edge after two synchroniser stages
	assign syncSeen = ((syncSync_r == polarity) && (syncPrev_r != polarity));
	// Count code to characters per pulse, minus one
	assign charLimit = (control_r[COUNT_LSB +: 3] > COUNT_MAX_CODE) ? 5'd0
		: 5'((6'd1 << control_r[COUNT_LSB +: 3]) - 6'd1);

	always_comb begin
		busState_nxt = busState_r;
		control_nxt  = control_r;
		readdata_nxt = readdata_r;
		for (int i = 0; i < 4; i++) begin
			beMask[i*8 +: 8] = {8{byteenable[i]}};
		end
		wrMask = CONTROL_WR_MASK & beMask;
		if (enabled) begin
			wrMask = wrMask & ~LOCKED_BITS_MASK;
		end
		unique case (busState_r)
			BUS_IDLE: begin
				if (write) begin
					if (address == CONTROL_OFFSET) begin
						control_nxt = (control_r & ~wrMask) | (writedata & wrMask);
					end
					busState_nxt = BUS_ACK;
				end else if (read) begin
					if (address == CONTROL_OFFSET) begin
						readdata_nxt = control_r;
					end else if (address == STATUS_OFFSET) begin
						readdata_nxt = {27'h000_0000, syncSync_r, selOe_r,
							pulseActive_r, frameStart_r, enabled};
					end else begin
						readdata_nxt = READ_UNMAPPED;
					end
					busState_nxt = BUS_ACK;
				end
			end
			BUS_ACK: begin
				busState_nxt = BUS_DONE;
			end
			BUS_DONE: begin
				busState_nxt = BUS_IDLE;
			end
		endcase
	end

	always_comb begin
		charCnt_nxt     = charCnt_r;
		pulseActive_nxt = pulseActive_r;
		frameStart_nxt  = 1'b0;
		selOut_nxt      = ~polarity;
		selOe_nxt       = 1'b0;
		clkSrc_nxt      = control_r[CLKSRC_BIT];
		idlePol_nxt     = audio_protocol_enable | control_r[IDLEPOL_BIT];
		edgeSel_nxt     = framed ? 1'b0 : control_r[EDGE_BIT];
		if (!enabled || !framed) begin
			charCnt_nxt     = 5'd0;
			pulseActive_nxt = 1'b0;
		end else if (syncIn) begin
			frameStart_nxt = syncSeen;
		end else begin
			// Master sync generation on character boundaries; at width 0 also after each serial clock of a group's first character
			if (pulseActive_r && (control_r[PULSEW_BIT] ? charDone : bitTick)) begin
				pulseActive_nxt = 1'b0;
			end
			if (charDone) begin
				if (charCnt_r >= charLimit) begin
					charCnt_nxt = 5'd0;
				end else begin
					charCnt_nxt = charCnt_r + 5'd1;
				end
			end
			if (xferActive && charCnt_r == 5'd0 && !pulseActive_r && !charDone) begin
				pulseActive_nxt = 1'b1;
				frameStart_nxt  = 1'b1;
			end
		end
		if (enabled && framed && !syncIn) begin
			selOe_nxt  = 1'b1;
			selOut_nxt = pulseActive_nxt ? polarity : ~polarity;
		end else if (enabled && !framed && control_r[MASTER_BIT]
				&& control_r[AUTOSEL_BIT]) begin
			selOe_nxt  = 1'b1;
			selOut_nxt = xferActive ? polarity : ~polarity;
		end
		// Serial in and out disable bits are stored only; routing is elsewhere
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			busState_r    <= BUS_IDLE;
			control_r     <= CONTROL_RESET;
			readdata_r    <= 32'h0000_0000;
			charCnt_r     <= 5'd0;
			pulseActive_r <= 1'b0;
			selOut_r      <= 1'b1;
			selOe_r       <= 1'b0;
			frameStart_r  <= 1'b0;
			clkSrc_r      <= 1'b0;
			idlePol_r     <= 1'b0;
			edgeSel_r     <= 1'b0;
			syncMeta_r    <= 1'b0;
			syncSync_r    <= 1'b0;
			syncPrev_r    <= 1'b0;
		end else begin
			busState_r    <= busState_nxt;
			control_r     <= control_nxt;
			readdata_r    <= readdata_nxt;
			charCnt_r     <= charCnt_nxt;
			pulseActive_r <= pulseActive_nxt;
			selOut_r      <= selOut_nxt;
			selOe_r       <= selOe_nxt;
			frameStart_r  <= frameStart_nxt;
			clkSrc_r      <= clkSrc_nxt;
			idlePol_r     <= idlePol_nxt;
			edgeSel_r     <= edgeSel_nxt;
			syncMeta_r    <= selectPinIn;
			syncSync_r    <= syncMeta_r;
			syncPrev_r    <= syncSync_r;
		end
	end

	// waitrequest high except in the acknowledge cycle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= ~(busState_r == BUS_IDLE && (read || write));
		end
	end

	assign readdata              = readdata_r;
	assign selectPinOut          = selOut_r;
	assign selectPinOe           = selOe_r;
	assign frameStart            = frameStart_r;
	assign baudClockSourceSel    = clkSrc_r;
	assign effectiveIdlePolarity = idlePol_r;
	assign effectiveEdgeSel      = edgeSel_r;
endmodule
`default_nettype wire

// ### spi_framing_control_properties.sv
// Checker of the framing control block ports
`timescale 1ns/10ps
`default_nettype none
module spi_framing_checker (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic read,
	input wire logic write,
	input wire logic waitrequest,
	input wire logic audio_protocol_enable,
	input wire logic xferActive,
	input wire logic selectPinIn,
	input wire logic frameStart,
	input wire logic baudClockSourceSel,
	input wire logic effectiveIdlePolarity
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	chk_ack_arrives: assert property ($rose(read || write) |-> ##[1:3] !waitrequest)
		else $error("ack late");
	chk_ack_gap: assert property (!waitrequest |=> waitrequest [*2])
		else $error("ack gap short");
	chk_idle_no_ack: assert property (!(read || write) |=> waitrequest)
		else $error("ack without request");
	chk_audio_polarity: assert property (audio_protocol_enable |=> effectiveIdlePolarity)
		else $error("idle polarity not forced");
	chk_source_by_write: assert property (
		$changed(baudClockSourceSel) |-> $past(write) || $past(write, 2)) else $error("source moved");
	chk_source_steady: assert property (!write [*3] |-> $stable(baudClockSourceSel))
		else $error("source unstable");
	chk_sync_pulse: assert property (frameStart |=> !frameStart)
		else $error("sync start too long");
	chk_sync_quiet: assert property (
		(!xferActive && $stable(selectPinIn)) [*6] |-> !frameStart) else $error("sync without cause");
endmodule
`default_nettype wire

// ### spi_framing_pkg.sv
// Register map, field positions and constants for the framing control block
package spi_framing_pkg;
	localparam logic [3:0]  CONTROL_OFFSET   = 4'h0;
	localparam logic [3:0]  STATUS_OFFSET    = 4'h4;
	localparam logic [31:0] CONTROL_RESET    = 32'h0000_0000;
	localparam logic [31:0] CONTROL_WR_MASK  = 32'hFF83_BFFF;
	localparam logic [31:0] LOCKED_BITS_MASK = 32'h0081_0000;
	localparam int FRAMED_BIT     = 31;
	localparam int SYNCDIR_BIT    = 30;
	localparam int SYNCPOL_BIT    = 29;
	localparam int AUTOSEL_BIT    = 28;
	localparam int PULSEW_BIT     = 27;
	localparam int COUNT_LSB      = 24;
	localparam int CLKSRC_BIT     = 23;
	localparam int ENHANCED_BUFFER_ENABLE_BIT     = 16;
	localparam int ENABLE_BIT     = 15;
	localparam int OUTDIS_BIT     = 12;
	localparam int EDGE_BIT       = 8;
	localparam int MASTER_BIT     = 5;
	localparam int INDIS_BIT      = 4;
	localparam int IDLEPOL_BIT    = 6;
	localparam logic [2:0]  COUNT_MAX_CODE = 3'h5;
	localparam logic [31:0] READ_UNMAPPED  = 32'h0000_0000;
endpackage

// ### tb.sv
// Bench for the framing control block
`timescale 1ns/10ps
`default_nettype none
module tb;
	import spi_framing_pkg::*;
	logic        mclk, rstn, read, write, waitrequest, audio_protocol_enable, charDone, bitTick;
	logic        xferActive, selectPinIn, selectPinOut, selectPinOe, frameStart, baudClockSourceSel;
	logic        effectiveIdlePolarity, effectiveEdgeSel, syncPulse, syncActiveHigh;
	logic [3:0]  address;
	logic [3:0]  byteenable = 4'hF;
	logic [31:0] writedata, readdata, rdGot;
	int          errorCnt = 0, compares = 0, cycles = 0, pulses = 0, base;
	spi_framing_control uut (.*);
	spi_far_peer peer (.*);
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (frameStart === 1'b1)
			pulses <= pulses + 1;
		if (cycles == 30000) begin
			errorCnt++;
			tally_and_finish();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errorCnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		do @(posedge mclk); while (waitrequest !== 1'b0);
		rdGot = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0000_0000);
		check(what, rdGot, exp);
	endtask
	task automatic tally_and_finish();
		$display("Compares %0d mismatches %0d", compares, errorCnt);
		if (errorCnt == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		{rstn, read, write, audio_protocol_enable, xferActive, syncPulse, syncActiveHigh} = 7'h01;
		address = 4'h0;
		writedata = 32'h0000_0000;
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		rd(4'h0, CONTROL_RESET, "control at reset");
		rd(4'h8, READ_UNMAPPED, "unmapped");
		bus(1'b1, 4'h0, 32'hFFFF_FFFF);
		rd(4'h0, CONTROL_WR_MASK, "implemented bits");
		check("clock source", baudClockSourceSel, 1);
		check("edge in framed", effectiveEdgeSel, 0);
		bus(1'b1, 4'h0, 32'h0000_0000);
		rd(4'h0, LOCKED_BITS_MASK, "locked while on");
		bus(1'b1, 4'h0, 32'h0000_8100);
		rd(4'h0, 32'h0000_8100, "plain mode");
		check("source cleared", baudClockSourceSel, 0);
		check("edge kept", effectiveEdgeSel, 1);
		check("idle polarity", effectiveIdlePolarity, 0);
		audio_protocol_enable <= 1'b1;
		repeat (2) @(posedge mclk);
		check("idle forced", effectiveIdlePolarity, 1);
		audio_protocol_enable <= 1'b0;
		for (int p = 0; p < 2; p++) begin
			bus(1'b1, 4'h0, 32'h1000_8020 | (p << 29));
			xferActive <= 1'b1;
			repeat (4) @(posedge mclk);
			check("auto select", {selectPinOe, selectPinOut}, {1'b1, p[0]});
			xferActive <= 1'b0;
		end
		for (int c = 0; c < 6; c++) begin
			bus(1'b1, 4'h0, 32'h0000_0000);
			bus(1'b1, 4'h0, 32'hA800_8020 | (c << 24));
			base = pulses;
			xferActive <= 1'b1;
			repeat (32) @(posedge charDone);
			check("sync driven", selectPinOe, 1);
			xferActive <= 1'b0;
			repeat (4) @(posedge mclk);
			check("pulses per code", pulses - base, 32 >> c);
		end
		rd(STATUS_OFFSET, 32'h0000_0009, "status framed master");
		for (int p = 0; p < 2; p++) begin
			bus(1'b1, 4'h0, 32'h0000_0000);
			syncActiveHigh <= p[0];
			bus(1'b1, 4'h0, 32'hC000_8000 | (p << 29));
			base = pulses;
			syncPulse <= 1'b1;
			repeat (6) @(posedge mclk);
			check("sync leading", pulses - base, 1);
			syncPulse <= 1'b0;
			repeat (6) @(posedge mclk);
			check("sync trailing", pulses - base, 1);
			check("sync input", selectPinOe, 0);
		end
		tally_and_finish();
	end
endmodule
bind spi_framing_control spi_framing_checker chk (.*);
`default_nettype wire
